// ===== pkg/fss_pkg.sv
// fault status / stop mode register bank: shared constants and types
// assumes 16-bit holding-register style access, 32-bit values split over two words
package fss_pkg;

  // register word addresses (32-bit values: high word at offset, low word at offset+1)
  localparam logic [15:0] OFF_ERR_PRI    = 16'h1f00;
  localparam logic [15:0] OFF_ERR_SEC    = 16'h2000;
  localparam logic [15:0] OFF_QS_DECEL   = 16'h3300;
  localparam logic [15:0] OFF_QS_MODE    = 16'h3400;
  localparam logic [15:0] OFF_SD_MODE    = 16'h3410;
  localparam logic [15:0] OFF_DIS_MODE   = 16'h3420;
  localparam logic [15:0] OFF_PAUSE_MODE = 16'h3430;
  localparam logic [15:0] OFF_ERR_MODE   = 16'h3440;
  localparam logic [15:0] OFF_PROF_DECEL = 16'h4c00;
  localparam logic [15:0] OFF_TEMP_ALARM = 16'h7180;
  localparam logic [15:0] OFF_TEMP_READ  = 16'h7190;
  localparam logic [15:0] OFF_UV_POINT   = 16'h8670;
  localparam logic [15:0] OFF_CHOP_POINT = 16'h8680;
  localparam logic [15:0] OFF_OV_POINT   = 16'h8690;

  // values after reset (decelerations held in hundredths of rps/s)
  localparam logic [15:0] RST_ERR_PRI    = 16'h0408;
  localparam logic [15:0] RST_ERR_SEC    = 16'h0000;
  localparam logic [31:0] RST_PROF_DECEL = 32'h0000_2710;
  localparam logic [31:0] RST_QS_DECEL   = 32'h0000_ee48;
  localparam logic [15:0] RST_STOP_MODE  = 16'h0000;
  localparam logic [15:0] RST_PAUSE_MODE = 16'h0001;
  localparam logic [15:0] RST_TEMP_ALARM = 16'h0064;
  localparam logic [15:0] RST_UV_POINT   = 16'h0012;
  localparam logic [15:0] RST_CHOP_POINT = 16'h003f;
  localparam logic [15:0] RST_OV_POINT   = 16'h0046;
  localparam logic [15:0] TEMP_NO_SENSOR = 16'hffd8;

  // fault bit positions
  localparam int BIT_OVERVOLT  = 5;
  localparam int BIT_UNDERVOLT = 6;
  localparam int BIT_MOTOR_TMP = 13;
  localparam int BIT_POS_LIMIT = 9;
  localparam int BIT_NEG_LIMIT = 10;
  localparam logic [15:0] SEC_RSV_MASK = 16'hff1f;

  // stop codes and control word patterns
  localparam logic [15:0] CODE_FREE     = 16'h0000;
  localparam logic [15:0] CODE_RAMP     = 16'h0001;
  localparam logic [15:0] CODE_QS_OFF   = 16'h0002;
  localparam logic [15:0] CODE_PROF_QSA = 16'h0005;
  localparam logic [15:0] CODE_QS_QSA   = 16'h0006;
  localparam logic [15:0] CODE_WINDING  = 16'h0012;
  localparam logic [15:0] CW_QUICK_STOP = 16'h000b;
  localparam int          CW_PAUSE_BIT  = 8;
  localparam logic [7:0]  WMODE_PROF_A  = 8'h01;
  localparam logic [7:0]  WMODE_PROF_B  = 8'h03;

  // stop sequencer states
  typedef enum logic [3:0] {
    FSS_IDLE = 4'b0001,
    FSS_STOP = 4'b0010,
    FSS_HOLD = 4'b0100,
    FSS_OFF  = 4'b1000
  } fss_state_t;

  // which request started the stop
  typedef enum logic [2:0] {
    SRC_NONE, SRC_ERROR, SRC_QUICK, SRC_DISABLE, SRC_SHUTDOWN, SRC_PAUSE
  } fss_src_t;

  // stop command towards the motion controller
  typedef struct packed {
    logic        active;
    logic        uncontrolled;
    logic        winding_brake;
    logic        qs_active;
    logic        switch_off;
    logic [31:0] decel;
  } fss_stop_t;

endpackage

// ===== logic/fss_sync3.sv
// three-stage input synchroniser with agreement filter, one per bit
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ns
module fss_sync3 #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // async in, filtered out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // s1 is read only by s2; output moves once s2 and s3 agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1[g]     <= 1'b0;
          s2[g]     <= 1'b0;
          s3[g]     <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          s1[g] <= async_i[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            sync_o[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  sync_agree_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (s2 == s3) |=> (sync_o == $past(s3)))
    else $error("synchroniser output did not follow agreed stages");

endmodule

// ===== logic/fss_regs.sv
// fault status words, stop mode selection and alarm thresholds for a servo drive
// assumes a 16-bit word register port in the clk_i domain; pins pass fss_sync3
//
// Functional notes
// - primary word bits 0-7: extended, encoder faults, temperature, over/under voltage, overcurrent
// - primary word bits 8-15: chopper, following, logic volt, overload, frequency, motor temp, etc
// - secondary bits 0-4: sensor, watchdog, interrupt, identity, configuration; 5-7 reserved zero
// - secondary bits 8-15: enable, limits, serial, connection, direction, master encoder, counting
// - quick stop runs on limit switch, emergency stop, or control word 0x000B; limit bits also raise fault_any, so an error stop replaces it unless code 0
// - quick stop codes 5 and 6 decelerate then stay quick-stop-active
// - codes 0,1,2 mean free stop, ramp then off, quick decel then off
// - code 18 brakes with motor windings, valid for four stop mode fields
// - control word bit 8 pauses enabled motor; code 1 ramp, 2 quick decel
// - profile deceleration 32-bit, default 100.00, applied in working modes 1 and 3
// - quick stop deceleration 32-bit, default 610.00, used by quick decel codes
// - motor temperature alarm threshold signed 16-bit, default 100
// - motor temperature reads -40 when sensor missing or abnormal
// - undervoltage threshold unsigned 16-bit, default 18
// - chopper activation threshold unsigned 16-bit, default 63
// - overvoltage threshold unsigned 16-bit, default 70
`timescale 1ns/1ns
module fss_regs (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // register port
  input  wire logic [15:0]       reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  output logic                   reg_ack_o,
  output logic                   reg_err_o,
  // fault pins
  input  wire logic [15:0]       fault_pri_i,
  input  wire logic [15:0]       fault_sec_i,
  input  wire logic              limit_pos_i,
  input  wire logic              limit_neg_i,
  input  wire logic              estop_i,
  // measurements and drive state
  input  wire logic [15:0]       bus_voltage_i,
  input  wire logic [15:0]       motor_temp_raw_i,
  input  wire logic              temp_sensor_ok_i,
  input  wire logic [15:0]       ctrl_word_i,
  input  wire logic              shutdown_req_i,
  input  wire logic              disable_req_i,
  input  wire logic              motor_stopped_i,
  input  wire logic [7:0]        work_mode_i,
  // stop and alarm outputs
  output fss_pkg::fss_stop_t     stop_cmd_o,
  output logic                   prof_decel_apply_o,
  output logic                   chopper_on_o,
  output logic                   fault_any_o
);

  // registers
  logic [15:0] err_pri;
  logic [15:0] err_sec;
  logic [31:0] qs_decel;
  logic [31:0] prof_decel;
  logic [15:0] qs_mode;
  logic [15:0] sd_mode;
  logic [15:0] dis_mode;
  logic [15:0] pause_mode;
  logic [15:0] err_mode;
  logic [15:0] temp_alarm;
  logic [15:0] temp_read;
  logic [15:0] uv_point;
  logic [15:0] chop_point;
  logic [15:0] ov_point;

  // synchronised pins
  logic [15:0] pri_pin;
  logic [15:0] sec_pin;
  logic [2:0]  sw_pin;

  fss_sync3 #(.WIDTH(16)) u_sync_pri (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (fault_pri_i),
    .sync_o   (pri_pin)
  );
  fss_sync3 #(.WIDTH(16)) u_sync_sec (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (fault_sec_i),
    .sync_o   (sec_pin)
  );
  fss_sync3 #(.WIDTH(3)) u_sync_sw (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({estop_i, limit_neg_i, limit_pos_i}),
    .sync_o   (sw_pin)
  );

  // live threshold comparisons; temperature compare is signed
  wire over_volt  = bus_voltage_i > ov_point;
  wire under_volt = bus_voltage_i < uv_point;
  wire motor_hot  = temp_sensor_ok_i && ($signed(motor_temp_raw_i) >= $signed(temp_alarm));

  // assemble live status words
  logic [15:0] pri_live;
  logic [15:0] sec_live;
  always_comb begin
    pri_live = pri_pin;
    pri_live[fss_pkg::BIT_OVERVOLT]  = over_volt;
    pri_live[fss_pkg::BIT_UNDERVOLT] = under_volt;
    pri_live[fss_pkg::BIT_MOTOR_TMP] = motor_hot;
    sec_live = sec_pin & fss_pkg::SEC_RSV_MASK;
    sec_live[fss_pkg::BIT_POS_LIMIT] = sw_pin[0];
    sec_live[fss_pkg::BIT_NEG_LIMIT] = sw_pin[1];
  end

  // status words are live, not sticky: no clear path needed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_pri   <= fss_pkg::RST_ERR_PRI;
      err_sec   <= fss_pkg::RST_ERR_SEC;
      temp_read <= fss_pkg::TEMP_NO_SENSOR;
    end else begin
      err_pri   <= pri_live;
      err_sec   <= sec_live;
      temp_read <= temp_sensor_ok_i ? motor_temp_raw_i : fss_pkg::TEMP_NO_SENSOR;
    end
  end

  // address decode
  wire hit_pri   = reg_addr_i == fss_pkg::OFF_ERR_PRI;
  wire hit_sec   = reg_addr_i == fss_pkg::OFF_ERR_SEC;
  wire hit_qsd_h = reg_addr_i == fss_pkg::OFF_QS_DECEL;
  wire hit_qsd_l = reg_addr_i == fss_pkg::OFF_QS_DECEL + 16'h0001;
  wire hit_qsm   = reg_addr_i == fss_pkg::OFF_QS_MODE;
  wire hit_sdm   = reg_addr_i == fss_pkg::OFF_SD_MODE;
  wire hit_dism  = reg_addr_i == fss_pkg::OFF_DIS_MODE;
  wire hit_pm    = reg_addr_i == fss_pkg::OFF_PAUSE_MODE;
  wire hit_em    = reg_addr_i == fss_pkg::OFF_ERR_MODE;
  wire hit_pd_h  = reg_addr_i == fss_pkg::OFF_PROF_DECEL;
  wire hit_pd_l  = reg_addr_i == fss_pkg::OFF_PROF_DECEL + 16'h0001;
  wire hit_ta    = reg_addr_i == fss_pkg::OFF_TEMP_ALARM;
  wire hit_tr    = reg_addr_i == fss_pkg::OFF_TEMP_READ;
  wire hit_uv    = reg_addr_i == fss_pkg::OFF_UV_POINT;
  wire hit_ch    = reg_addr_i == fss_pkg::OFF_CHOP_POINT;
  wire hit_ov    = reg_addr_i == fss_pkg::OFF_OV_POINT;
  wire hit_ro    = hit_pri | hit_sec | hit_tr;
  wire hit_rw    = hit_qsd_h | hit_qsd_l | hit_qsm | hit_sdm | hit_dism | hit_pm | hit_em |
                   hit_pd_h | hit_pd_l | hit_ta | hit_uv | hit_ch | hit_ov;

  // stop code legality; an illegal code is refused and the old one kept
  wire w_free    = reg_wdata_i == fss_pkg::CODE_FREE;
  wire w_ramp    = reg_wdata_i == fss_pkg::CODE_RAMP;
  wire w_qsoff   = reg_wdata_i == fss_pkg::CODE_QS_OFF;
  wire w_wind    = reg_wdata_i == fss_pkg::CODE_WINDING;
  wire code_base = w_free | w_ramp | w_qsoff | w_wind;
  wire code_qsa  = (reg_wdata_i == fss_pkg::CODE_PROF_QSA) | (reg_wdata_i == fss_pkg::CODE_QS_QSA);
  wire code_ok   = hit_qsm ? (code_base | code_qsa) :
                   (hit_sdm | hit_dism | hit_em) ? code_base :
                   hit_pm ? (w_ramp | w_qsoff) : 1'b1;
  wire wr_ok     = reg_wr_i && hit_rw && code_ok;
  wire acc_bad   = (reg_wr_i && !(hit_rw && code_ok)) || (reg_rd_i && !(hit_rw || hit_ro));

  // writable registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      qs_decel   <= fss_pkg::RST_QS_DECEL;
      prof_decel <= fss_pkg::RST_PROF_DECEL;
      qs_mode    <= fss_pkg::RST_STOP_MODE;
      sd_mode    <= fss_pkg::RST_STOP_MODE;
      dis_mode   <= fss_pkg::RST_STOP_MODE;
      err_mode   <= fss_pkg::RST_STOP_MODE;
      pause_mode <= fss_pkg::RST_PAUSE_MODE;
      temp_alarm <= fss_pkg::RST_TEMP_ALARM;
      uv_point   <= fss_pkg::RST_UV_POINT;
      chop_point <= fss_pkg::RST_CHOP_POINT;
      ov_point   <= fss_pkg::RST_OV_POINT;
    end else if (wr_ok) begin
      if (hit_qsd_h) qs_decel[31:16]   <= reg_wdata_i;
      if (hit_qsd_l) qs_decel[15:0]    <= reg_wdata_i;
      if (hit_pd_h)  prof_decel[31:16] <= reg_wdata_i;
      if (hit_pd_l)  prof_decel[15:0]  <= reg_wdata_i;
      if (hit_qsm)   qs_mode    <= reg_wdata_i;
      if (hit_sdm)   sd_mode    <= reg_wdata_i;
      if (hit_dism)  dis_mode   <= reg_wdata_i;
      if (hit_em)    err_mode   <= reg_wdata_i;
      if (hit_pm)    pause_mode <= reg_wdata_i;
      if (hit_ta)    temp_alarm <= reg_wdata_i;
      if (hit_uv)    uv_point   <= reg_wdata_i;
      if (hit_ch)    chop_point <= reg_wdata_i;
      if (hit_ov)    ov_point   <= reg_wdata_i;
    end
  end

  // read selection
  wire [15:0] rd_mux =
    hit_pri   ? err_pri           : hit_sec   ? err_sec          :
    hit_qsd_h ? qs_decel[31:16]   : hit_qsd_l ? qs_decel[15:0]   :
    hit_pd_h  ? prof_decel[31:16] : hit_pd_l  ? prof_decel[15:0] :
    hit_qsm   ? qs_mode           : hit_sdm   ? sd_mode          :
    hit_dism  ? dis_mode          : hit_pm    ? pause_mode       :
    hit_em    ? err_mode          : hit_ta    ? temp_alarm       :
    hit_tr    ? temp_read         : hit_uv    ? uv_point         :
    hit_ch    ? chop_point        : hit_ov    ? ov_point         : 16'h0000;

  // answer one cycle after the strobe; unmapped reads return zero with error
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o   <= 1'b0;
      reg_err_o   <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
      reg_ack_o   <= reg_rd_i | reg_wr_i;
      reg_err_o   <= acc_bad;
    end
  end

  // stop requests in priority order: error, quick stop, disable, shutdown, pause
  wire fault_any = (|err_pri) | (|err_sec);
  wire qs_req    = sw_pin[0] | sw_pin[1] | sw_pin[2] | (ctrl_word_i == fss_pkg::CW_QUICK_STOP);
  wire pause_req = ctrl_word_i[fss_pkg::CW_PAUSE_BIT];
  wire any_req   = fault_any | qs_req | disable_req_i | shutdown_req_i | pause_req;
  wire fss_pkg::fss_src_t arb_src =
    fault_any      ? fss_pkg::SRC_ERROR    :
    qs_req         ? fss_pkg::SRC_QUICK    :
    disable_req_i  ? fss_pkg::SRC_DISABLE  :
    shutdown_req_i ? fss_pkg::SRC_SHUTDOWN : fss_pkg::SRC_PAUSE;
  wire [15:0] arb_code =
    fault_any      ? err_mode :
    qs_req         ? qs_mode  :
    disable_req_i  ? dis_mode :
    shutdown_req_i ? sd_mode  : pause_mode;

  fss_pkg::fss_state_t state;
  fss_pkg::fss_state_t next_state;
  fss_pkg::fss_src_t   src;
  fss_pkg::fss_src_t   next_src;
  logic [15:0]         code;
  logic [15:0]         next_code;

  // a fault overrides a milder stop in the stop or hold state, not one already switched off
  wire escalate = fault_any && (src != fss_pkg::SRC_ERROR);
  wire is_free  = (arb_code == fss_pkg::CODE_FREE) && (arb_src != fss_pkg::SRC_PAUSE);
  wire stay_qsa = ((src == fss_pkg::SRC_QUICK) && ((code == fss_pkg::CODE_PROF_QSA) ||
                  (code == fss_pkg::CODE_QS_QSA))) || (src == fss_pkg::SRC_PAUSE);

  // stop sequencer
  always_comb begin
    next_state = state;
    next_src   = src;
    next_code  = code;
    unique case (state)
      fss_pkg::FSS_IDLE: begin
        if (any_req) begin
          next_src   = arb_src;
          next_code  = arb_code;
          next_state = is_free ? fss_pkg::FSS_OFF : fss_pkg::FSS_STOP;
        end
      end
      fss_pkg::FSS_STOP: begin
        if (escalate) begin
          next_src   = arb_src;
          next_code  = arb_code;
          next_state = is_free ? fss_pkg::FSS_OFF : fss_pkg::FSS_STOP;
        end else if (motor_stopped_i) begin
          next_state = stay_qsa ? fss_pkg::FSS_HOLD : fss_pkg::FSS_OFF;
        end
      end
      fss_pkg::FSS_HOLD: begin
        if (escalate) begin
          next_src   = arb_src;
          next_code  = arb_code;
          next_state = is_free ? fss_pkg::FSS_OFF : fss_pkg::FSS_STOP;
        end else if (!any_req) begin
          next_state = fss_pkg::FSS_IDLE;
          next_src   = fss_pkg::SRC_NONE;
        end
      end
      fss_pkg::FSS_OFF: begin
        if (!any_req) begin
          next_state = fss_pkg::FSS_IDLE;
          next_src   = fss_pkg::SRC_NONE;
        end
      end
      default: begin
        next_state = fss_pkg::FSS_IDLE;
        next_src   = fss_pkg::SRC_NONE;
      end
    endcase
  end

  // deceleration chosen by the latched code
  wire use_qs   = (next_code == fss_pkg::CODE_QS_OFF) || (next_code == fss_pkg::CODE_QS_QSA);
  wire use_prof = (next_code == fss_pkg::CODE_RAMP) || (next_code == fss_pkg::CODE_PROF_QSA);
  fss_pkg::fss_stop_t next_cmd;
  always_comb begin
    next_cmd               = '0;
    next_cmd.active        = next_state != fss_pkg::FSS_IDLE;
    next_cmd.uncontrolled  = (next_state == fss_pkg::FSS_OFF) && (next_code == fss_pkg::CODE_FREE);
    next_cmd.winding_brake = (next_state == fss_pkg::FSS_STOP) && (next_code == fss_pkg::CODE_WINDING);
    next_cmd.qs_active     = (next_state == fss_pkg::FSS_HOLD) && (next_src == fss_pkg::SRC_QUICK);
    next_cmd.switch_off    = next_state == fss_pkg::FSS_OFF;
    next_cmd.decel         = use_qs ? qs_decel : use_prof ? prof_decel : 32'h0000_0000;
  end

  // sequencer state and registered outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state              <= fss_pkg::FSS_IDLE;
      src                <= fss_pkg::SRC_NONE;
      code               <= fss_pkg::RST_STOP_MODE;
      stop_cmd_o         <= '0;
      prof_decel_apply_o <= 1'b0;
      chopper_on_o       <= 1'b0;
      fault_any_o        <= 1'b0;
    end else begin
      state              <= next_state;
      src                <= next_src;
      code               <= next_code;
      stop_cmd_o         <= next_cmd;
      prof_decel_apply_o <= (work_mode_i == fss_pkg::WMODE_PROF_A) || (work_mode_i == fss_pkg::WMODE_PROF_B);
      chopper_on_o       <= bus_voltage_i >= chop_point;
      fault_any_o        <= fault_any;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence qs_settle_s;
    (state == fss_pkg::FSS_STOP) && (src == fss_pkg::SRC_QUICK) && !fault_any && motor_stopped_i;
  endsequence

  sec_reserved_a: assert property (err_sec[7:5] == 3'b000)
    else $error("reserved secondary bits set");
  ov_flag_a: assert property (over_volt |=> err_pri[fss_pkg::BIT_OVERVOLT])
    else $error("overvoltage flag missed");
  uv_clear_a: assert property (!under_volt |=> !err_pri[fss_pkg::BIT_UNDERVOLT])
    else $error("undervoltage flag not cleared");
  temp_nosensor_a: assert property (!temp_sensor_ok_i |=> temp_read == fss_pkg::TEMP_NO_SENSOR)
    else $error("missing sensor not shown as -40");
  qs_hold_a: assert property (qs_settle_s ##0 (code == fss_pkg::CODE_QS_QSA)
    |=> (state == fss_pkg::FSS_HOLD) ##0 stop_cmd_o.qs_active)
    else $error("quick stop code 6 did not hold");
  free_stop_a: assert property ((state == fss_pkg::FSS_IDLE) && fault_any && (err_mode == fss_pkg::CODE_FREE)
    |=> stop_cmd_o.uncontrolled && stop_cmd_o.switch_off)
    else $error("code 0 error stop not uncontrolled");
  cw_qstop_a: assert property ((state == fss_pkg::FSS_IDLE) && !fault_any && (ctrl_word_i == fss_pkg::CW_QUICK_STOP)
    |=> stop_cmd_o.active ##0 (src == fss_pkg::SRC_QUICK))
    else $error("control word quick stop not taken");
  pause_on_a: assert property ((state == fss_pkg::FSS_HOLD) && (src == fss_pkg::SRC_PAUSE)
    |-> !stop_cmd_o.switch_off)
    else $error("pause switched the motor off");
  qs_decel_a: assert property (stop_cmd_o.active && (code == fss_pkg::CODE_QS_OFF)
    && $stable(qs_decel) |-> stop_cmd_o.decel == qs_decel)
    else $error("quick stop deceleration not applied");
  wind_code_a: assert property (reg_wr_i && hit_em && (reg_wdata_i == fss_pkg::CODE_WINDING)
    |=> (err_mode == fss_pkg::CODE_WINDING) && reg_ack_o && !reg_err_o)
    else $error("winding brake code refused");
  rd_answer_a: assert property (reg_rd_i && hit_ov |=> reg_ack_o && !reg_err_o && (reg_rdata_o == ov_point))
    else $error("overvoltage point read wrong");

endmodule

// ===== verification/fss_host.sv
// host model: one word access at a time on the drive's register port
// assumes the bench clock; strobes move 1 ns after a rising edge
`timescale 1ns/1ns
module fss_host (
  // clock
  input  wire logic        clk_i,
  // register port
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [15:0] wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        ack_i,
  input  wire logic        err_i
);
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  // one-cycle strobe; answer read while ack stands, a missing ack counts as error
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q, output logic e);
    @(posedge clk_i);
    #1 {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(posedge clk_i);
    #1 {wr_o, rd_o} = 2'b00;
    q = rdata_i;
    e = err_i | !ack_i;
  endtask
endmodule

// ===== verification/fss_regs_bench.sv
// self-checking bench for the fault status and stop mode register bank
// assumes fss_host drives the word port; pins settle within six cycles
`timescale 1ns/1ns
module fss_regs_bench;
  logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, e;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q, d, fault_pri_i = '0, fault_sec_i = '0;
  logic [15:0] bus_voltage_i = 16'h0032, motor_temp_raw_i = 16'h0014, ctrl_word_i = '0;
  logic limit_pos_i = 0, limit_neg_i = 0, estop_i = 0, temp_sensor_ok_i = 1, shutdown_req_i = 0;
  logic disable_req_i = 0, motor_stopped_i = 0, prof_decel_apply_o, chopper_on_o, fault_any_o;
  logic [7:0] work_mode_i = 8'h01;
  fss_pkg::fss_stop_t stop_cmd_o;
  int fails = 0, num_checks = 0, cyc = 0;
  logic [15:0] ra [11] = '{16'h3400, 16'h3410, 16'h3420, 16'h3430, 16'h3440, 16'h7180, 16'h8670,
                          16'h8680, 16'h8690, 16'h4c01, 16'h3301};
  logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0064, 16'h0012,
                          16'h003f, 16'h0046, 16'h2710, 16'hee48};
  logic [15:0] qc [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0012};
  fss_regs u_fss_regs (.clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .reg_ack_o, .reg_err_o, .fault_pri_i, .fault_sec_i, .limit_pos_i, .limit_neg_i, .estop_i,
    .bus_voltage_i, .motor_temp_raw_i, .temp_sensor_ok_i, .ctrl_word_i, .shutdown_req_i, .disable_req_i,
    .motor_stopped_i, .work_mode_i, .stop_cmd_o, .prof_decel_apply_o, .chopper_on_o, .fault_any_o);
  fss_host u_fss_host (.clk_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o), .ack_i(reg_ack_o), .err_i(reg_err_o));
  always #5 clk_i = ~clk_i;
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [39:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rdchk(input logic [15:0] a, x);
    u_fss_host.xfer(1'b0, a, 16'h0000, q, e);
    chk({e, q}, {1'b0, x});
  endtask
  task automatic wrchk(input logic [15:0] a, v, input logic x);
    u_fss_host.xfer(1'b1, a, v, q, e);
    chk(e, x);
  endtask
  // primary word: pins, with voltage and temperature bits from the compares
  function automatic logic [15:0] pri_exp(input logic [15:0] f, v, t, input logic ok);
    pri_exp = f & 16'hdf9f;
    pri_exp[5] = v > 16'h0046;
    pri_exp[6] = v < 16'h0012;
    pri_exp[13] = ok && $signed(t) >= 16'sh0064;
  endfunction
  initial begin
    void'($urandom(32'h1ddf_901f));
    step(5);
    resetn_i = 1'b1;
    foreach (ra[i]) rdchk(ra[i], rv[i]);
    // random pins; voltage and temperature straddle the alarm points
    repeat (8) begin
      {fault_pri_i, fault_sec_i} = $urandom();
      bus_voltage_i = 16'($urandom_range(90, 0));
      motor_temp_raw_i = 16'($urandom_range(110, 90));
      temp_sensor_ok_i = 1'($urandom());
      work_mode_i = 8'($urandom_range(4, 0));
      step(6);
      d = pri_exp(fault_pri_i, bus_voltage_i, motor_temp_raw_i, temp_sensor_ok_i);
      rdchk(16'h1f00, d);
      rdchk(16'h2000, fault_sec_i & 16'hf91f);
      rdchk(16'h7190, temp_sensor_ok_i ? motor_temp_raw_i : 16'hffd8);
      chk(chopper_on_o, bus_voltage_i >= 16'h003f);
      chk(prof_decel_apply_o, work_mode_i == 8'h01 || work_mode_i == 8'h03);
      chk(fault_any_o, |{d, fault_sec_i & 16'hf91f});
    end
    {limit_pos_i, limit_neg_i} = 2'b11;
    step(6);
    rdchk(16'h2000, fault_sec_i & 16'hf91f | 16'h0600);
    // refusals and every quick stop code
    wrchk(16'h1f00, 16'h0000, 1'b1);
    wrchk(16'h5555, 16'h0000, 1'b1);
    foreach (qc[i]) wrchk(16'h3400, qc[i], 1'b0);
    wrchk(16'h3400, 16'h0003, 1'b1);
    rdchk(16'h3400, 16'h0012);
    wrchk(16'h3440, 16'h0005, 1'b1);
    wrchk(16'h3430, 16'h0000, 1'b1);
    d = 16'($urandom());
    wrchk(16'h8690, d, 1'b0);
    rdchk(16'h8690, d);
    // clear every request, then quick stop by control word at mode 6
    {fault_pri_i, fault_sec_i, limit_pos_i, limit_neg_i, bus_voltage_i} = {34'h0, 16'h0032};
    temp_sensor_ok_i = 1'b1;
    motor_temp_raw_i = 16'h0014;
    wrchk(16'h8690, 16'h0046, 1'b0);
    wrchk(16'h3301, d, 1'b0);
    wrchk(16'h3400, 16'h0006, 1'b0);
    wrchk(16'h3430, 16'h0002, 1'b0);
    step(8);
    ctrl_word_i = 16'h000b;
    step(3);
    chk(stop_cmd_o, {5'b10000, 16'h0000, d});
    motor_stopped_i = 1'b1;
    step(3);
    chk({stop_cmd_o.qs_active, stop_cmd_o.switch_off}, 2'b10);
    // quick-stop-active ends only once every request is gone; pause starts from idle
    ctrl_word_i = 16'h0000;
    step(2);
    chk(stop_cmd_o.active, 1'b0);
    ctrl_word_i = 16'h0100;
    step(4);
    chk(stop_cmd_o, {5'b10000, 16'h0000, d});
    {ctrl_word_i, motor_stopped_i} = 17'h0;
    wrchk(16'h3440, 16'h0012, 1'b0);
    step(3);
    fault_pri_i = 16'h0080;
    step(8);
    chk({stop_cmd_o.active, stop_cmd_o.winding_brake}, 2'b11);
    // disable stop with ramp code: profile deceleration, then switch-off
    fault_pri_i = 16'h0000;
    motor_stopped_i = 1'b1;
    wrchk(16'h3420, 16'h0001, 1'b0);
    step(8);
    {motor_stopped_i, disable_req_i} = 2'b01;
    step(2);
    chk(stop_cmd_o, {5'b10000, 32'h0000_2710});
    motor_stopped_i = 1'b1;
    step(2);
    chk(stop_cmd_o, {5'b10001, 32'h0000_2710});
    summarize();
  end
endmodule
